// ### core/main_osc_ctrl.sv
// Main oscillator control: enable, startup countdown, stable flag,
// frequency measurement, interrupt, AXI4-Lite register slave.
// Assumes slow and main clocks arrive as pins asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module main_osc_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register bus
  input wire osc_ctrl_pkg::axi_req_t axi_req,
  output osc_ctrl_pkg::axi_rsp_t axi_rsp,
  // Clock pins
  input wire logic slow_clk_in,
  input wire logic main_clk_in,
  // Oscillator control
  output logic main_osc_enable,
  output logic osc_input_tie_low,
  output logic slow_clock_select,
  // Interrupt
  output logic irq
);
  import osc_ctrl_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  osc_state_t st_r;
  osc_state_t st_nxt;
  logic slow_rise;
  logic slow_fall;
  logic main_rise;
  logic wr_go;
  logic rd_go;
  logic ev_clr;
  logic en_new;
  logic [EV_W-1:0] ev_set;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Slow clock edges, time base of all counting
  pin_sync u_slow_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(slow_clk_in),
    .level(),
    .rise(slow_rise),
    .fall(slow_fall)
  );

  // Main clock edges for the frequency counter
  pin_sync u_main_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(main_clk_in),
    .level(),
    .rise(main_rise),
    .fall()
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    ev_set = '0;
    ev_clr = 1'b0;
    rd_word = '0;
    rd_resp = RESP_OKAY;
    en_new = st_r.osc_en;

    // Write address capture
    if (axi_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end

    // Write data capture
    if (axi_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_data = axi_req.wdata;
      st_nxt.w_strb = axi_req.wstrb;
    end

    // Write execute once both halves are held
    wr_go = st_r.aw_full && st_r.w_full && !st_r.rsp.bvalid;
    if (wr_go) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = RESP_OKAY;
      unique case (st_r.aw_addr)
        OFS_MAIN_OSC: begin
          if (st_r.w_strb[STRB_EN]) begin
            en_new = st_r.w_data[ENABLE_BIT];
          end
          if (st_r.w_strb[STRB_CNT]) begin
            st_nxt.count = st_r.w_data[COUNT_LSB +: CNT_W];
          end
        end
        OFS_IRQ_MASK: begin
          if (st_r.w_strb[STRB_EN]) begin
            st_nxt.mask = st_r.w_data[EV_W-1:0];
          end
        end
        OFS_STATUS, OFS_IRQ_STAT, OFS_FREQ: begin
          st_nxt.rsp.bresp = RESP_OKAY;
        end
        default: begin
          st_nxt.rsp.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Write response retire
    if (st_r.rsp.bvalid && axi_req.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end

    // Read response retire
    if (st_r.rsp.rvalid && axi_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end

    // Read decode
    rd_go = axi_req.arvalid && st_r.rsp.arready;
    if (rd_go) begin
      unique case (axi_req.araddr)
        OFS_MAIN_OSC: begin
          rd_word[ENABLE_BIT] = st_r.osc_en;
          rd_word[COUNT_LSB +: CNT_W] = st_r.count;
        end
        OFS_STATUS: begin
          rd_word[STABLE_BIT] = st_r.stable;
        end
        OFS_IRQ_STAT: begin
          rd_word[EV_W-1:0] = st_r.ev;
          ev_clr = 1'b1;
        end
        OFS_IRQ_MASK: begin
          rd_word[EV_W-1:0] = st_r.mask;
        end
        OFS_FREQ: begin
          rd_word[DONE_BIT] = st_r.done;
          rd_word[MEAS_W-1:0] = st_r.meas_cnt;
        end
        default: begin
          rd_resp = RESP_SLVERR;
        end
      endcase
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata = rd_word;
      st_nxt.rsp.rresp = rd_resp;
    end

    // Frequency measurement on synchronised clock edges
    unique case (st_r.meas)
      MEAS_IDLE: begin
        if (st_r.stable && slow_rise) begin
          st_nxt.meas = MEAS_RUN;
          st_nxt.meas_cnt = '0;
          st_nxt.falls = '0;
        end
      end
      MEAS_RUN: begin
        if (main_rise) begin
          st_nxt.meas_cnt = st_r.meas_cnt + MEAS_W'(1);
        end
        if (slow_fall) begin
          st_nxt.falls = st_r.falls + FALL_W'(1);
          if (st_r.falls == FALL_LAST) begin
            st_nxt.meas = MEAS_DONE;
            st_nxt.done = 1'b1;
            ev_set[EV_DONE] = 1'b1;
          end
        end
      end
      MEAS_DONE: begin
        st_nxt.meas_cnt = st_r.meas_cnt;
      end
    endcase

    // Oscillator enable and startup countdown
    st_nxt.osc_en = en_new;
    if (!en_new) begin
      st_nxt.osc_st = OSC_OFF;
      st_nxt.stable = 1'b0;
      st_nxt.meas = MEAS_IDLE;
      st_nxt.meas_cnt = '0;
      st_nxt.falls = '0;
      st_nxt.done = 1'b0;
    end else if (!st_r.osc_en) begin
      st_nxt.osc_st = OSC_START;
      st_nxt.stable = 1'b0;
      st_nxt.down = st_nxt.count;
      st_nxt.pre = '0;
    end else begin
      unique case (st_r.osc_st)
        OSC_START: begin
          if (st_r.down == '0) begin
            st_nxt.osc_st = OSC_STABLE;
            st_nxt.stable = 1'b1;
            ev_set[EV_STABLE] = 1'b1;
          end else if (slow_rise) begin
            st_nxt.pre = st_r.pre + PRE_W'(1);
            if (st_r.pre == PRE_LAST) begin
              st_nxt.down = st_r.down - CNT_W'(1);
            end
          end
        end
        OSC_OFF, OSC_STABLE: begin
          st_nxt.pre = st_r.pre;
        end
      endcase
    end

    // Sticky events, a new event beats the read clear
    st_nxt.ev = (ev_clr ? '0 : st_r.ev) | ev_set;

    // Handshake readiness for the next cycle
    st_nxt.rsp.awready = !st_nxt.aw_full && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready = !st_nxt.w_full && !st_nxt.rsp.bvalid;
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // Registered pin outputs
    st_nxt.irq = |(st_nxt.ev & st_nxt.mask);
    st_nxt.xin_tie = !en_new;
    st_nxt.slow_sel = !st_nxt.stable;
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Reset leaves the oscillator off and slow clock selected
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= OSC_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign axi_rsp = st_r.rsp;
  assign main_osc_enable = st_r.osc_en;
  assign osc_input_tie_low = st_r.xin_tie;
  assign slow_clock_select = st_r.slow_sel;
  assign irq = st_r.irq;

endmodule // main_osc_ctrl

`default_nettype wire

// ### core/osc_ctrl_pkg.sv
// Shared types and constants of the main oscillator control block.
// Assumes a single ref_clk domain and an AXI4-Lite master outside.
`default_nettype none

package osc_ctrl_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [31:0] OFS_MAIN_OSC = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_IRQ_STAT = 32'h0000_0008;
  localparam logic [31:0] OFS_IRQ_MASK = 32'h0000_000c;
  localparam logic [31:0] OFS_FREQ = 32'h0000_0010;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int ENABLE_BIT = 0;
  localparam int COUNT_LSB = 8;
  localparam int CNT_W = 8;
  localparam int STABLE_BIT = 0;
  localparam int EV_STABLE = 0;
  localparam int EV_DONE = 1;
  localparam int EV_W = 2;
  localparam int DONE_BIT = 16;
  localparam int MEAS_W = 16;
  localparam int PRE_W = 3;
  localparam int FALL_W = 5;
  localparam int STRB_EN = 0;
  localparam int STRB_CNT = 1;

  // ************************************************************
  // Counts and bus answers
  // ************************************************************
  localparam logic [PRE_W-1:0] PRE_LAST = 3'h7;
  localparam logic [FALL_W-1:0] FALL_LAST = 5'h0f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef enum logic [1:0] {OSC_OFF, OSC_START, OSC_STABLE} osc_phase_t;
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_RUN, MEAS_DONE} meas_phase_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } sync_state_t;

  typedef struct packed {
    axi_rsp_t rsp;
    logic aw_full;
    logic [31:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic osc_en;
    logic [CNT_W-1:0] count;
    osc_phase_t osc_st;
    logic stable;
    logic [CNT_W-1:0] down;
    logic [PRE_W-1:0] pre;
    meas_phase_t meas;
    logic [MEAS_W-1:0] meas_cnt;
    logic [FALL_W-1:0] falls;
    logic done;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] mask;
    logic irq;
    logic xin_tie;
    logic slow_sel;
  } osc_state_t;

  localparam osc_state_t OSC_STATE_RST = '{
    xin_tie: 1'b1,
    slow_sel: 1'b1,
    osc_st: OSC_OFF,
    meas: MEAS_IDLE,
    default: '0
  };

endpackage

`default_nettype wire

// ### core/pin_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes pin_in is asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pin side
  input wire logic pin_in,
  // Filtered level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  import osc_ctrl_pkg::*;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // ************************************************************
  // Next state
  // ************************************************************
  // Level moves only when stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.lvl) begin
      st_nxt.lvl = st_r.s3;
      st_nxt.rise = st_r.s3;
      st_nxt.fall = ~st_r.s3;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign level = st_r.lvl;
  assign rise = st_r.rise;
  assign fall = st_r.fall;

endmodule // pin_sync

`default_nettype wire

// ### verification/osc_ctrl_checker.sv
// Port assertions and covers for the main oscillator control block.
// Assumes one ref_clk domain; bound to main_osc_ctrl below.
`timescale 1ns/100ps
`default_nettype none

module osc_ctrl_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register bus
  input wire osc_ctrl_pkg::axi_req_t axi_req,
  input wire osc_ctrl_pkg::axi_rsp_t axi_rsp,
  // Clock pins
  input wire logic slow_clk_in,
  input wire logic main_clk_in,
  // Oscillator control and interrupt
  input wire logic main_osc_enable,
  input wire logic osc_input_tie_low,
  input wire logic slow_clock_select,
  input wire logic irq
);
  import osc_ctrl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Oscillator control
  // ****************************************
  a_tie_follows_en: assert property (
    osc_input_tie_low == !main_osc_enable) else $error("tie low wrong");
  a_start_keeps_slow: assert property (
    $rose(main_osc_enable) |-> slow_clock_select)
    else $error("stable too early");
  a_off_selects_slow: assert property (
    !main_osc_enable |=> slow_clock_select) else $error("slow not selected");
  a_stable_needs_en: assert property (
    $fell(slow_clock_select) |-> main_osc_enable)
    else $error("stable while disabled");

  // ****************************************
  // Register bus
  // ****************************************
  a_write_answer: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid) else $error("write answer late");
  a_write_refused: assert property (
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while busy");
  a_write_ready_back: assert property (
    axi_rsp.bvalid && axi_req.bready |=> axi_rsp.awready && axi_rsp.wready)
    else $error("write ready not back");
  a_read_answer: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer wrong");

  // Main scenarios
  c_stable: cover property ($fell(slow_clock_select));
  c_irq: cover property ($rose(irq));
  c_disable: cover property ($fell(main_osc_enable));
endmodule // osc_ctrl_checker

bind main_osc_ctrl osc_ctrl_checker u_chk (.ref_clk, .sys_rst, .axi_req,
  .axi_rsp, .slow_clk_in, .main_clk_in, .main_osc_enable,
  .osc_input_tie_low, .slow_clock_select, .irq);

`default_nettype wire

// ### verification/tb_main_osc_ctrl.sv
// Self-checking bench for the main oscillator control block.
// Assumes the package and checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none

module tb_main_osc_ctrl;
  import osc_ctrl_pkg::*;
  localparam int SP = 40;
  localparam int MP = 10;
  localparam int LIMIT = 20000;
  logic ref_clk, sys_rst, slow_clk_in, main_clk_in;
  logic main_osc_enable, osc_input_tie_low, slow_clock_select, irq;
  axi_req_t axi_req;
  axi_rsp_t axi_rsp;
  int mismatches, compares, cyc, n, t;
  logic [31:0] seed, d;
  logic [1:0] r;
  logic [31:0] e;
  // Register model kept from the rules
  int m_en, m_cnt, m_mask, m_ev, m_stab, m_freq;

  main_osc_ctrl DUT (.ref_clk, .sys_rst, .axi_req, .axi_rsp, .slow_clk_in,
    .main_clk_in, .main_osc_enable, .osc_input_tie_low, .slow_clock_select,
    .irq);

  // ****************************************
  // Clocks, pins and timeout
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Slow and main clock pins, never on the same cycle
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc % (SP / 2) == 0) slow_clk_in <= ~slow_clk_in;
    if (cyc % (MP / 2) == 2) main_clk_in <= ~main_clk_in;
    if (cyc == LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // Expected read word from the register model
  function automatic logic [31:0] model_rd(input logic [31:0] a);
    case (a)
      OFS_MAIN_OSC: return 32'(m_en) | (32'(m_cnt) << COUNT_LSB);
      OFS_STATUS: return 32'(m_stab);
      OFS_IRQ_STAT: return 32'(m_ev);
      OFS_IRQ_MASK: return 32'(m_mask);
      OFS_FREQ: return 32'(m_freq);
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  // Write one word, release each channel when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    axi_req.awaddr <= a;
    axi_req.wdata <= v;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    // Model follows the write
    if (a == OFS_IRQ_MASK) m_mask = int'(v[EV_W-1:0]);
    if (a == OFS_MAIN_OSC) begin
      if (v[ENABLE_BIT] != m_en[0]) m_stab = 0;
      if (!v[ENABLE_BIT]) m_freq = 0;
      m_en = int'(v[ENABLE_BIT]);
      m_cnt = int'(v[COUNT_LSB +: CNT_W]);
    end
  endtask

  // Read one word into d and r, model word into e
  task automatic rd(input logic [31:0] a);
    e = model_rd(a);
    if (a == OFS_IRQ_STAT) m_ev = 0;
    @(posedge ref_clk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  task automatic final_report();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {sys_rst, slow_clk_in, main_clk_in} = 3'b100;
    axi_req = '0;
    cyc = 0;
    seed = 32'h94f2;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // Reset state of pins and registers
    chk_pin(main_osc_enable, 1'b0);
    chk_pin(osc_input_tie_low, 1'b1);
    chk_pin(slow_clock_select, 1'b1);
    chk_pin(irq, 1'b0);
    for (int a = 0; a <= 16; a += 4) begin
      rd(a);
      chk(d, e);
    end
    rd(32'h14);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_STATUS, 32'hffff_ffff);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    $display("test reset done");
    // Startup countdown with random count
    seed = xs(seed);
    n = 2 + seed % 3;
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_MAIN_OSC, (n << COUNT_LSB) | 1);
    rd(OFS_MAIN_OSC);
    chk(d, e);
    chk_pin(osc_input_tie_low, 1'b0);
    t = 12;
    while (slow_clock_select === 1'b1) begin
      @(posedge ref_clk);
      t++;
    end
    chk_pin(t >= (8 * n - 1) * SP && t <= (8 * n + 1) * SP, 1'b1);
    m_stab = 1;
    m_ev = m_ev | 1;
    rd(OFS_STATUS);
    chk(d, e);
    chk_pin(irq, 1'b1);
    rd(OFS_IRQ_STAT);
    chk(d, e);
    $display("test startup done");
    // Frequency measurement over sixteen slow falls
    // Main rises from a slow rise to the sixteenth slow fall after it
    m_freq = 32'h1_0000 | ((32 * SP / 2 - SP / 2) / MP);
    m_ev = m_ev | 2;
    do rd(OFS_FREQ); while (d[DONE_BIT] !== 1'b1);
    chk(d, e);
    chk_pin(irq, 1'b1);
    rd(OFS_IRQ_STAT);
    chk(d, e);
    repeat (2) @(posedge ref_clk);
    chk_pin(irq, 1'b0);
    $display("test measure done");
    // Disable, then restart with count zero and mask off
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_MAIN_OSC, 32'h0);
    chk_pin(osc_input_tie_low, 1'b1);
    chk_pin(slow_clock_select, 1'b1);
    rd(OFS_STATUS);
    chk(d, e);
    rd(OFS_FREQ);
    chk(d, e);
    wr(OFS_MAIN_OSC, 32'h1);
    repeat (4) @(posedge ref_clk);
    m_stab = 1;
    m_ev = m_ev | 1;
    chk_pin(slow_clock_select, 1'b0);
    chk_pin(irq, 1'b0);
    rd(OFS_IRQ_STAT);
    chk(d, e);
    $display("test disable done");
    final_report();
  end
endmodule // tb_main_osc_ctrl

`default_nettype wire
